/* design/sltc_defs.svh */
/*
  Constants of the serial link transmit control block: register
  indices, field positions, reset values, control codes.
  Assumes it is included by the design and bench files.
*/
`ifndef SLTC_DEFS_SVH
`define SLTC_DEFS_SVH
// Register indices; byte address is four times the index
`define SLTC_IDX_TEST   8'h2A
`define SLTC_IDX_OVR    8'h2B
`define SLTC_IDX_SCR    8'h2F
`define SLTC_IDX_OPF    8'h30
`define SLTC_IDX_FPM    8'h31
`define SLTC_IDX_STAT   8'h32
// Fields of the test and alignment register, and the scramble register bit
`define SLTC_B_LONG     5
`define SLTC_B_CODE     4
`define SLTC_B_REV      3
`define SLTC_B_LANE     2
`define SLTC_B_FRAME    1
`define SLTC_B_ILADIS   0
`define SLTC_B_SCR      7
// Reset value, fixed frames per multiframe, four-octet code
`define SLTC_RST_FPM    5'h08
`define SLTC_K_FIXED    5'h09
`define SLTC_OPF_40X    8'h03
// Codes
`define SLTC_SYNC_K     16'hBCBC
`define SLTC_SYNC_ALT   16'hBC50
`define SLTC_PAT_CLK    16'hAAAA
`define SLTC_PAT_ENC    16'hFF00
`define SLTC_K28_0      8'h1C
`define SLTC_K28_3      8'h7C
`define SLTC_K28_7      8'hFC
`define SLTC_ILA_MF     2'h3
`define SLTC_PRBS_SEED  15'h7FFF
`endif

/* design/sltc_pkg.sv */
/*
  Types of the serial link transmit control block.
  Assumes sltc_defs.svh is reachable by its bare name.
*/
package sltc_pkg;
  typedef enum logic [1:0] {
    ST_SYNC,
    ST_ILA,
    ST_DATA
  } sltc_state_t;

  // One lane word: two octets and their control-character flags
  typedef struct packed {
    logic [15:0] data;
    logic [1:0]  k;
  } sltc_lane_t;
endpackage

/* design/sltc_buf.sv */
/*
  Small FIFO with valid and ready on both sides.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/100ps
module sltc_buf #(
  parameter int W     = 18,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* design/sltc_prbs.sv */
/*
  Pseudo-random 2^15-1 word source, sixteen bits per advance.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/100ps
`include "sltc_defs.svh"
module sltc_prbs (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control and word
  input  wire logic adv,
  output logic [15:0] word
);
  logic [14:0] lfsr;

  function automatic logic [30:0] step16(input logic [14:0] s);
    logic [14:0] st;
    logic [15:0] w;
    st = s;
    w  = '0;
    for (int i = 15; i >= 0; i--) begin
      w[i] = st[14] ^ st[13];
      st   = {st[13:0], w[i]};
    end
    return {st, w};
  endfunction

  wire [30:0] nxt = step16(lfsr);
  assign word = nxt[15:0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr <= `SLTC_PRBS_SEED;
    end else if (adv) begin
      lfsr <= nxt[30:16];
    end
  end
endmodule

/* design/sltc_core.sv */
/*
  Serial link transmit control: APB registers, sync code, initial
  alignment, test patterns, sample reversal, scrambling and alignment
  character insertion, feeding a two-entry output buffer.
  Assumes a zero-wait APB master, samples offered with valid/ready,
  and a lane consumer that may stall with lane_ready.
*/
`timescale 1ns/100ps
`include "sltc_defs.svh"
module sltc_core #(
  parameter int         SW    = 14,
  parameter logic [4:0] K_FIX = `SLTC_K_FIXED
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Link sync request from the receiver
  input  wire logic               sync_req_n,
  // Sample stream
  input  wire logic               sample_valid,
  input  wire logic [SW-1:0]      sample,
  output logic                    sample_ready,
  // Lane word stream
  output logic                    lane_valid,
  output sltc_pkg::sltc_lane_t    lane_out,
  input  wire logic               lane_ready
);
  import sltc_pkg::*;

  // Registers
  logic [7:0]  link_test_align_ctrl;
  logic [1:0]  frame_param_override;
  logic        scramble_ctrl;
  logic [7:0]  opf_reg;
  logic [4:0]  fpm_reg;

  // Sequencing state
  sltc_state_t state;
  sltc_state_t next_state;
  logic        word_idx;
  logic [4:0]  frame_cnt;
  logic [1:0]  mf_cnt;
  logic [14:0] scr_state;

  function automatic logic addr_hit(input logic [11:0] a,
                                    input logic [7:0] idx);
    return (a[9:2] == idx) && (a[1:0] == 2'b00) && (a[11:10] == 2'b00);
  endfunction

  function automatic logic [SW-1:0] bit_rev(input logic [SW-1:0] v);
    logic [SW-1:0] r;
    r = '0;
    for (int i = 0; i < SW; i++) begin
      r[i] = v[SW-1-i];
    end
    return r;
  endfunction

  function automatic logic [30:0] scramble(input logic [14:0] s,
                                           input logic [15:0] d);
    logic [14:0] st;
    logic [15:0] o;
    st = s;
    o  = '0;
    for (int i = 15; i >= 0; i--) begin
      o[i] = d[i] ^ st[14] ^ st[13];
      st   = {st[13:0], o[i]};
    end
    return {st, o};
  endfunction

  // Control fields
  wire [1:0] lane_test_pattern_sel = link_test_align_ctrl[7:6];
  wire long_test       = link_test_align_ctrl[`SLTC_B_LONG];
  wire sync_code_sel   = link_test_align_ctrl[`SLTC_B_CODE];
  wire data_rev        = link_test_align_ctrl[`SLTC_B_REV];
  wire lane_align      = link_test_align_ctrl[`SLTC_B_LANE];
  wire frame_align     = link_test_align_ctrl[`SLTC_B_FRAME];
  wire align_seq_disable = link_test_align_ctrl[`SLTC_B_ILADIS];
  wire scrambler_on    = scramble_ctrl;

  // Frame geometry
  wire [4:0] k_frames = frame_param_override[1] ? fpm_reg : K_FIX;
  wire four_oct = frame_param_override[0]
                  && (opf_reg == `SLTC_OPF_40X);
  wire [4:0] k_last   = (k_frames == 5'h00) ? 5'h00 : k_frames - 5'h01;
  wire last_word  = !four_oct || word_idx;
  wire last_frame = (frame_cnt >= k_last);
  wire mf_end     = last_word && last_frame;

  // APB decode
  wire hit_test = addr_hit(paddr, `SLTC_IDX_TEST);
  wire hit_ovr  = addr_hit(paddr, `SLTC_IDX_OVR);
  wire hit_scr  = addr_hit(paddr, `SLTC_IDX_SCR);
  wire hit_opf  = addr_hit(paddr, `SLTC_IDX_OPF);
  wire hit_fpm  = addr_hit(paddr, `SLTC_IDX_FPM);
  wire hit_stat = addr_hit(paddr, `SLTC_IDX_STAT);
  wire hit_any  = hit_test | hit_ovr | hit_scr | hit_opf | hit_fpm
                  | hit_stat;
  wire acc      = psel && penable;
  wire wr_en    = acc && pwrite;
  wire [7:0] stat_val = {(state == ST_SYNC), (state == ST_ILA),
                         (state == ST_DATA), frame_cnt};
  wire [7:0] rd_byte =
      hit_test ? link_test_align_ctrl :
      hit_ovr  ? {6'h00, frame_param_override} :
      hit_scr  ? {scramble_ctrl, 7'h00} :
      hit_opf  ? opf_reg :
      hit_fpm  ? {3'h0, fpm_reg} :
      hit_stat ? stat_val : 8'h00;
  assign pready  = 1'b1;
  assign pslverr = acc && !hit_any;
  assign prdata  = {24'h000000, rd_byte};

  // Word sources
  logic        buf_in_ready;
  logic [15:0] prbs_word;
  wire [SW-1:0] samp_ord = data_rev ? bit_rev(sample) : sample;
  wire [15:0] samp_word = 16'({samp_ord, {(16-SW){1'b0}}});
  wire [30:0] scr_res   = scramble(scr_state, samp_word);
  wire [15:0] lt_word   = {3'h0, frame_cnt, 7'h00, word_idx};
  wire use_samples = (state == ST_DATA) && (lane_test_pattern_sel == 2'b00)
                     && !long_test;
  wire [15:0] sync_word = sync_code_sel ? `SLTC_SYNC_ALT
                                        : `SLTC_SYNC_K;
  wire [1:0]  sync_k    = sync_code_sel ? 2'b10 : 2'b11;

  // Data-state payload
  wire [15:0] pay_word =
      (lane_test_pattern_sel == 2'b01) ? `SLTC_PAT_CLK :
      (lane_test_pattern_sel == 2'b10) ? `SLTC_PAT_ENC :
      (lane_test_pattern_sel == 2'b11) ? prbs_word :
      long_test    ? lt_word :
      scrambler_on ? scr_res[15:0] : samp_word;
  wire ins_lane  = lane_align && mf_end;
  wire ins_frame = frame_align && last_word && !ins_lane;
  wire [15:0] data_word =
      ins_lane  ? {pay_word[15:8], `SLTC_K28_3} :
      ins_frame ? {pay_word[15:8], `SLTC_K28_7} : pay_word;
  wire [1:0] data_k = {1'b0, ins_lane | ins_frame};

  // Initial alignment words: K28.0 opens, K28.3 closes a multiframe
  wire ila_first = (frame_cnt == 5'h00) && !word_idx;
  wire [15:0] ila_word =
      mf_end    ? {8'h00, `SLTC_K28_3} :
      ila_first ? {`SLTC_K28_0, 8'h00} : {3'h0, frame_cnt, 8'h00};
  wire [1:0] ila_k = mf_end ? 2'b01 : (ila_first ? 2'b10 : 2'b00);

  sltc_lane_t gen_word;
  assign gen_word.data = (state == ST_SYNC) ? sync_word :
                         (state == ST_ILA)  ? ila_word : data_word;
  assign gen_word.k    = (state == ST_SYNC) ? sync_k :
                         (state == ST_ILA)  ? ila_k : data_k;
  wire gen_valid = !use_samples || sample_valid;
  wire fire      = gen_valid && buf_in_ready;
  assign sample_ready = use_samples && buf_in_ready;

  // Sequence
  always_comb begin
    next_state = state;
    case (state)
      ST_SYNC: begin
        if (sync_req_n && fire) begin
          next_state = align_seq_disable ? ST_DATA : ST_ILA;
        end
      end
      ST_ILA: begin
        if (fire && mf_end && (mf_cnt == `SLTC_ILA_MF)) begin
          next_state = ST_DATA;
        end
      end
      ST_DATA: next_state = state;
      default: next_state = ST_SYNC;
    endcase
    if (!sync_req_n) begin
      next_state = ST_SYNC;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_SYNC;
    end else begin
      state <= next_state;
    end
  end

  // Frame and multiframe counters
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_idx  <= 1'b0;
      frame_cnt <= 5'h00;
      mf_cnt    <= 2'h0;
    end else if (state == ST_SYNC || next_state != state) begin
      word_idx  <= 1'b0;
      frame_cnt <= 5'h00;
      mf_cnt    <= 2'h0;
    end else if (fire) begin
      word_idx  <= last_word ? 1'b0 : 1'b1;
      frame_cnt <= !last_word ? frame_cnt :
                   (last_frame ? 5'h00 : frame_cnt + 5'h01);
      mf_cnt    <= mf_end ? mf_cnt + 2'h1 : mf_cnt;
    end
  end

  // Scrambler state advances only on scrambled sample words
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scr_state <= 15'h0000;
    end else if (fire && use_samples && scrambler_on) begin
      scr_state <= scr_res[30:16];
    end
  end

  // Register writes; unused bits are dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_test_align_ctrl <= 8'h00;
      frame_param_override <= 2'h0;
      scramble_ctrl        <= 1'b0;
      opf_reg              <= 8'h00;
      fpm_reg              <= `SLTC_RST_FPM;
    end else if (wr_en) begin
      if (hit_test) link_test_align_ctrl <= pwdata[7:0];
      if (hit_ovr)  frame_param_override <= pwdata[1:0];
      if (hit_scr)  scramble_ctrl <= pwdata[`SLTC_B_SCR];
      if (hit_opf)  opf_reg <= pwdata[7:0];
      if (hit_fpm)  fpm_reg <= pwdata[4:0];
    end
  end

  sltc_prbs u_prbs (
    .clk   (clk),
    .rst_n (rst_n),
    .adv   (fire && state == ST_DATA && lane_test_pattern_sel == 2'b11),
    .word  (prbs_word)
  );

  sltc_buf #(
    .W     ($bits(sltc_lane_t)),
    .DEPTH (2)
  ) u_buf (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (gen_valid),
    .in_data   (gen_word),
    .in_ready  (buf_in_ready),
    .out_valid (lane_valid),
    .out_data  (lane_out),
    .out_ready (lane_ready)
  );

  // Checks
  a_sync_code_word: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state == ST_SYNC) && fire |->
      gen_word.data == (sync_code_sel ? 16'hBC50 : 16'hBCBC))
    else $error("sync code word wrong");

  a_pattern_fixed: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state == ST_DATA) && fire && !ins_lane && !ins_frame
      && lane_test_pattern_sel[1] != lane_test_pattern_sel[0] |->
      gen_word.data == (lane_test_pattern_sel[0] ? 16'hAAAA : 16'hFF00))
    else $error("fixed test pattern wrong");

  a_sample_reverse: assert property (
    @(posedge clk) disable iff (!rst_n)
    use_samples && fire && !scrambler_on && !ins_lane && !ins_frame |->
      gen_word.data[15:16-SW] ==
        (data_rev ? bit_rev(sample) : sample))
    else $error("sample order wrong");

  a_lane_char: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state == ST_DATA) && fire && lane_align && mf_end |->
      gen_word.data[7:0] == 8'h7C && gen_word.k[0])
    else $error("lane alignment char missing");

  a_frame_char: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state == ST_DATA) && fire && frame_align && last_word
      && !(lane_align && last_frame) |->
      gen_word.data[7:0] == 8'hFC && gen_word.k[0])
    else $error("frame alignment char missing");

  a_ila_skip: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state == ST_SYNC) && sync_req_n && fire |=>
      state == ($past(align_seq_disable) ? ST_DATA : ST_ILA))
    else $error("alignment sequence choice wrong");

  a_kframes_fixed: assert property (
    @(posedge clk) disable iff (!rst_n)
    !frame_param_override[1] |-> k_frames == 5'd9)
    else $error("fixed frames per multiframe wrong");

  a_octets_mode: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state == ST_DATA) && fire && !word_idx && four_oct |=>
      word_idx || (state != ST_DATA))
    else $error("four-octet frame too short");

  a_resync_now: assert property (
    @(posedge clk) disable iff (!rst_n)
    !sync_req_n |=> state == ST_SYNC)
    else $error("sync request not honoured");

  a_kframes_prog: assert property (
    @(posedge clk) disable iff (!rst_n)
    frame_param_override[1] |-> k_frames == fpm_reg)
    else $error("programmed frames per multiframe ignored");

  a_octets_two: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state == ST_DATA) && fire
      && (!frame_param_override[0] || opf_reg == 8'h00) |=>
      !word_idx || (state != ST_DATA))
    else $error("two-octet frame too long");

  a_ila_open: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state == ST_ILA) && fire && ila_first && !mf_end |->
      gen_word.data[15:8] == 8'h1C && gen_word.k == 2'b10)
    else $error("multiframe start char missing");

  a_ila_close: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state == ST_ILA) && fire && mf_end |->
      gen_word.data[7:0] == 8'h7C && gen_word.k == 2'b01)
    else $error("multiframe end char missing");

  a_sample_gate: assert property (
    @(posedge clk) disable iff (!rst_n)
    sample_ready |-> (state == ST_DATA) && !long_test
      && (lane_test_pattern_sel == 2'b00))
    else $error("sample taken outside data mode");

  a_lane_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    lane_valid && !lane_ready |=> lane_valid && $stable(lane_out))
    else $error("stalled lane word lost");
endmodule

/* testbench/sltc_rx_model.sv */
/*
  Lane receiver model: takes lane words over valid/ready, reports each.
  Assumes the bench drives stall from the same clock, high on random cycles only.
*/
`timescale 1ns/100ps
module sltc_rx_model (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Lane side
  input  wire logic                 lane_valid,
  input  wire sltc_pkg::sltc_lane_t lane_out,
  output logic                      lane_ready,
  // Bench side
  input  wire logic                 stall,
  output logic                      got,
  output sltc_pkg::sltc_lane_t      word
);
  import sltc_pkg::*;
  // Ready moves only after an edge; a word counts only when both are high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lane_ready <= 1'b0;
      got        <= 1'b0;
      word       <= '0;
    end else begin
      lane_ready <= !stall;
      got        <= lane_valid && lane_ready;
      if (lane_valid && lane_ready)
        word <= lane_out;
    end
  end
endmodule

/* testbench/sltc_core_test.sv */
/*
  Self-checking bench of the serial link transmit control block.
  Assumes the block's package and header and the lane receiver model.
*/
`timescale 1ns/100ps
`include "sltc_defs.svh"
module sltc_core_test;
  import sltc_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, sync_req_n = 1'b0, sample_valid = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rs = 32'h811B5EA0;
  logic [13:0] sample = 14'h0;
  logic        pready, pslverr, sample_ready, lane_valid, lane_ready, got;
  logic        stall = 1'b0, stall_en = 1'b0, skip = 1'b0;
  logic [17:0] skip_w, m;
  sltc_lane_t  lane_out, word, e;
  sltc_lane_t  exp_q[$];
  logic [17:0] msk_q[$];
  logic [7:0]  ridx[5] = '{8'h2A, 8'h2B, 8'h2F, 8'h30, 8'h31};
  logic [7:0]  rval[5] = '{8'hFF, 8'h03, 8'h80, 8'h03, 8'h1F};
  logic [7:0]  tv[4] = '{8'h41, 8'h81, 8'hC1, 8'h21};
  logic [14:0] scr_st = 15'h0000;
  int          mismatches = 0, checks_done = 0, cyc = 0;

  always #50 clk = ~clk;

  sltc_core i_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_req_n(sync_req_n), .sample_valid(sample_valid),
    .sample(sample), .sample_ready(sample_ready),
    .lane_valid(lane_valid), .lane_out(lane_out), .lane_ready(lane_ready));
  sltc_rx_model i_rx (.clk(clk), .rst_n(rst_n), .lane_valid(lane_valid),
    .lane_out(lane_out), .lane_ready(lane_ready), .stall(stall),
    .got(got), .word(word));

  function logic [31:0] nxt();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  function automatic void chk(input logic ok, input string what);
    checks_done++;
    if (!ok) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endfunction

  function automatic void push(input logic [17:0] v, input logic [17:0] mk);
    exp_q.push_back(v);
    msk_q.push_back(mk);
  endfunction

  task stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Random stalls of the receiver and the hang limit
  always @(posedge clk) begin
    stall <= stall_en && (nxt() < 32'h60000000);
    cyc   <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      stop_test();
    end
  end

  // Compares each received word, except skipped sync words, with the oldest expectation if one is queued
  always @(posedge clk) begin
    if (got === 1'b1 && !(skip && word === skip_w)) begin
      skip = 1'b0;
      if (exp_q.size() > 0) begin
        e = exp_q.pop_front();
        m = msk_q.pop_front();
        chk(((word ^ e) & m) === 18'h0, "lane word");
      end
    end
  end

  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [7:0] d, input logic err);
    int w;
    w = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h0, wr ? d : 8'h00};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      w++;
    end while (pready !== 1'b1 && w < 50);
    chk(w < 50 && pslverr === err, "bus response");
    if (!wr)
      chk(prdata === {24'h0, d}, "read data");
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic flush();
    stall_en <= 1'b0;
    repeat (8) @(posedge clk);
    stall_en <= 1'b1;
  endtask

  task automatic drain(input string name);
    int w;
    w = 0;
    while (exp_q.size() > 0 && w < 600) begin
      @(posedge clk);
      w++;
    end
    chk(exp_q.size() == 0, "words missing");
    $display("test %s done", name);
  endtask

  task automatic release_sync();
    skip_w = {`SLTC_SYNC_K, 2'b11};
    skip   = 1'b1;
    sync_req_n <= 1'b1;
    @(posedge clk);
  endtask

  task automatic push_ila(input int k);
    for (int f = 0; f < 4 * k; f++) begin
      if (f % k == 0)
        push({`SLTC_K28_0, 8'h00, 2'b10}, 18'h3FFFF);
      else if (f % k == k - 1)
        push({8'h00, `SLTC_K28_3, 2'b01}, 18'h3FFFF);
      else
        push(18'h0, 18'h003FF);
    end
  endtask

  task automatic send(input int n, input bit rev, input int mode);
    logic [13:0] s, r;
    logic [15:0] d;
    logic [1:0]  k;
    int          w;
    for (int i = 0; i < n; i++) begin
      s = 14'(nxt());
      r = {<<{s}};
      d = {rev ? r : s, 2'b00};
      k = 2'b00;
      if (mode == 1 || (mode == 2 && i % 2 == 1)) begin
        d[7:0] = `SLTC_K28_7;
        k = 2'b01;
      end
      if (mode == 3) begin
        d[7:0] = `SLTC_K28_3;
        k = 2'b01;
      end
      if (mode == 4) begin
        for (int b = 15; b >= 0; b--) begin
          d[b]   = d[b] ^ scr_st[14] ^ scr_st[13];
          scr_st = {scr_st[13:0], d[b]};
        end
      end
      push({d, k}, 18'h3FFFF);
      sample_valid <= 1'b1;
      sample       <= s;
      w = 0;
      do begin
        @(posedge clk);
        w++;
      end while (sample_ready !== 1'b1 && w < 400);
      chk(w < 400, "sample not taken");
    end
    sample_valid <= 1'b0;
    @(posedge clk);
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst_n    <= 1'b1;
    stall_en <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 5; i++)
      apb(1'b0, ridx[i], i == 4 ? 8'h08 : 8'h00, 1'b0);
    apb(1'b0, 8'h32, 8'h80, 1'b0);
    for (int i = 0; i < 5; i++)
      apb(1'b1, ridx[i], rval[i], 1'b0);
    for (int i = 0; i < 5; i++)
      apb(1'b0, ridx[i], rval[i], 1'b0);
    for (int i = 0; i < 5; i++)
      apb(1'b1, ridx[i], i == 4 ? 8'h08 : 8'h00, 1'b0);
    apb(1'b1, 8'h3F, 8'h5A, 1'b1);
    apb(1'b0, 8'h3F, 8'h00, 1'b1);
    $display("test registers done");
    for (int c = 0; c < 2; c++) begin
      apb(1'b1, 8'h2A, c ? 8'h10 : 8'h00, 1'b0);
      flush();
      chk(sample_ready === 1'b0, "sample taken in sync");
      repeat (4)
        push(c ? {`SLTC_SYNC_ALT, 2'b10} : {`SLTC_SYNC_K, 2'b11},
             18'h3FFFF);
      drain("sync code");
    end
    apb(1'b1, 8'h2A, 8'h00, 1'b0);
    flush();
    push_ila(9);
    release_sync();
    send(2, 1'b0, 0);
    drain("ila fixed");
    sync_req_n <= 1'b0;
    apb(1'b1, 8'h2B, 8'h02, 1'b0);
    apb(1'b1, 8'h31, 8'h03, 1'b0);
    flush();
    push_ila(3);
    release_sync();
    send(2, 1'b0, 0);
    drain("ila programmed");
    for (int o = 0; o < 2; o++) begin
      sync_req_n <= 1'b0;
      apb(1'b1, 8'h2B, 8'h01, 1'b0);
      apb(1'b1, 8'h30, o ? 8'h00 : 8'h03, 1'b0);
      apb(1'b1, 8'h2A, 8'h03, 1'b0);
      flush();
      release_sync();
      send(4, 1'b0, o ? 1 : 2);
      drain("octets per frame");
    end
    apb(1'b1, 8'h2A, 8'h01, 1'b0);
    apb(1'b1, 8'h2B, 8'h00, 1'b0);
    send(6, 1'b0, 0);
    apb(1'b1, 8'h2A, 8'h09, 1'b0);
    send(6, 1'b1, 0);
    apb(1'b1, 8'h2B, 8'h02, 1'b0);
    apb(1'b1, 8'h31, 8'h01, 1'b0);
    apb(1'b1, 8'h2A, 8'h05, 1'b0);
    send(4, 1'b0, 3);
    drain("sample data");
    apb(1'b1, 8'h2B, 8'h00, 1'b0);
    apb(1'b1, 8'h2A, 8'h01, 1'b0);
    apb(1'b1, 8'h2F, 8'h80, 1'b0);
    send(4, 1'b0, 4);
    apb(1'b1, 8'h2F, 8'h00, 1'b0);
    drain("scrambled data");
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, 8'h2A, tv[p], 1'b0);
      flush();
      chk(sample_ready === 1'b0, "sample taken in test mode");
      repeat (4)
        push({p == 0 ? `SLTC_PAT_CLK : `SLTC_PAT_ENC, 2'b00},
             p < 2 ? 18'h3FFFF : 18'h00003);
      drain("test pattern");
    end
    stop_test();
  end
endmodule
